// [logic/dmacms_top.sv]
`timescale 1ns/10ps
`default_nettype none
module dmacms_top
	import dmacms_pkg::*;
#(
	parameter int NCH = 8,
	parameter int AW = 32,
	parameter int CW = 24,
	parameter int CHW = $clog2(NCH),
	parameter int RAW = CHW + CH_SH
) (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic [RAW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic [NCH-1:0] CHANNEL_SERVICE_REQUEST,
	output logic BUS_HOLD_REQ,
	input wire logic BUS_HOLD_GRANT,
	output logic [ACK_W-1:0] ENCODED_CHANNEL_ACK,
	input wire logic END_OF_PROCESS_N_I,
	output logic END_OF_PROCESS_N_O,
	output logic END_OF_PROCESS_N_OE,
	output var dmacms_bus_s BUS_CYC,
	input wire logic [31:0] BUS_RDATA,
	input wire logic BUS_RDY,
	output logic CHAIN_RELOAD_INTERRUPT
);
	// ----------------------------------------
	// channel and engine storage
	// ----------------------------------------
	dmacms_mode_s mode_ff [NCH];
	logic [AW-1:0] breq_ff [NCH];
	logic [AW-1:0] btgt_ff [NCH];
	logic [CW-1:0] bcnt_ff [NCH];
	logic [AW-1:0] creq_ff [NCH];
	logic [AW-1:0] ctgt_ff [NCH];
	logic [CW-1:0] ccnt_ff [NCH];
	logic armed_ff [NCH];
	logic full_ff [NCH];
	logic irq_ff [NCH];
	logic tc_ff [NCH];
	logic [NCH-1:0] irq_v;
	logic [NCH-1:0] cand;
	dmacms_state_e st_ff;
	dmacms_state_e nxt_st;
	dmacms_bus_s nxt_bus;
	logic [CHW-1:0] act_ff;
	logic [31:0] data_ff;
	logic eop_seen_ff;
	logic eop_oe_ff;
	logic [ACK_W-1:0] ack_ff;
	logic [31:0] rdata_ff;

	// ----------------------------------------
	// requester phase decode
	// ----------------------------------------
	function automatic logic req_phase(input dmacms_state_e s, input logic dir);
		logic src;
		logic dst;
		src = (s == S_SRC1) | (s == S_SRC2);
		dst = (s == S_DST1) | (s == S_DST2);
		req_phase = (src & (dir == DIR_WRITE)) | (dst & (dir == DIR_READ));
	endfunction

	// ----------------------------------------
	// active channel view
	// ----------------------------------------
	wire dmacms_mode_s mode_act = mode_ff[act_ff];
	wire logic [AW-1:0] creq_act = creq_ff[act_ff];
	wire logic [AW-1:0] ctgt_act = ctgt_ff[act_ff];
	wire logic [CW-1:0] ccnt_act = ccnt_ff[act_ff];
	wire logic is_wr = (mode_act.dir == DIR_WRITE);
	wire logic [AW-1:0] src_addr = is_wr ? creq_act : ctgt_act;
	wire logic [AW-1:0] dst_addr = is_wr ? ctgt_act : creq_act;
	wire logic [AW-1:0] nxt_req;
	wire logic [AW-1:0] nxt_tgt;
	wire logic [CW-1:0] nxt_cnt = ccnt_act - CW'(1);
	wire logic tc_last = (ccnt_act == '0);
	wire logic req_now = req_phase(st_ff, mode_act.dir);
	wire logic req_nxt = req_phase(nxt_st, mode_act.dir);
	wire logic eop_in = ~END_OF_PROCESS_N_I & ~END_OF_PROCESS_N_OE;
	wire logic eop_hit = eop_in & req_now;
	wire logic xfer_end = (st_ff == S_DST2) & BUS_RDY;
	wire logic term = tc_last | eop_seen_ff | eop_hit;
	wire logic pick_vld;
	wire logic [CHW-1:0] pick_idx;

	dmacms_step #(.AW(AW)) u_req_step (
		.addr(creq_act),
		.step(mode_act.req_step),
		.nxt(nxt_req)
	);
	dmacms_step #(.AW(AW)) u_tgt_step (
		.addr(ctgt_act),
		.step(mode_act.tgt_step),
		.nxt(nxt_tgt)
	);
	dmacms_pick #(.N(NCH), .IW(CHW)) u_pick (
		.req(cand),
		.vld(pick_vld),
		.idx(pick_idx)
	);

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire logic [CHW-1:0] reg_ch = REG_ADDR[RAW-1:CH_SH];
	wire logic [2:0] reg_wd = REG_ADDR[CH_SH-1:WORD_SH];
	wire logic busy_rd = (st_ff != S_IDLE) & (act_ff == reg_ch);
	wire logic [31:0] stat_rd = 32'({busy_rd, tc_ff[reg_ch], irq_ff[reg_ch],
		full_ff[reg_ch], armed_ff[reg_ch]});
	wire logic [31:0] rd_mux = (reg_wd == WD_MODE) ? 32'(mode_ff[reg_ch]) :
		(reg_wd == WD_BREQ) ? 32'(breq_ff[reg_ch]) :
		(reg_wd == WD_BTGT) ? 32'(btgt_ff[reg_ch]) :
		(reg_wd == WD_BCNT) ? 32'(bcnt_ff[reg_ch]) :
		(reg_wd == WD_CREQ) ? 32'(creq_ff[reg_ch]) :
		(reg_wd == WD_CTGT) ? 32'(ctgt_ff[reg_ch]) :
		(reg_wd == WD_CCNT) ? 32'(ccnt_ff[reg_ch]) : stat_rd;
	wire dmacms_mode_s wmode = dmacms_mode_s'(REG_WDATA[MODE_W-1:0]);

	// ----------------------------------------
	// per-channel registers and buffer process
	// ----------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		wire logic hit = REG_WR & (reg_ch == CHW'(g));
		wire logic w_mode = hit & (reg_wd == WD_MODE);
		wire logic w_breq = hit & (reg_wd == WD_BREQ);
		wire logic w_btgt = hit & (reg_wd == WD_BTGT);
		wire logic w_bcnt = hit & (reg_wd == WD_BCNT);
		wire logic chain = (mode_ff[g].proc == PROC_CHAIN);
		wire logic start = w_mode & wmode.enable;
		wire logic start_chain = start & (wmode.proc == PROC_CHAIN);
		wire logic upd = xfer_end & (act_ff == CHW'(g));
		wire logic trm = upd & term;
		wire logic rld = trm & ((mode_ff[g].proc == PROC_AUTO) | (chain & full_ff[g]));
		wire logic stop = trm & ~rld;
		assign irq_v[g] = irq_ff[g];
		assign cand[g] = armed_ff[g] & CHANNEL_SERVICE_REQUEST[g];
		always_ff @(posedge MCLK) begin
			if (!RESETN) begin
				mode_ff[g] <= dmacms_mode_s'(MODE_RST);
				breq_ff[g] <= '0;
				btgt_ff[g] <= '0;
				bcnt_ff[g] <= '0;
			end else if (CE) begin
				if (w_mode) mode_ff[g] <= wmode;
				if (w_breq) breq_ff[g] <= REG_WDATA[AW-1:0];
				if (w_btgt) btgt_ff[g] <= REG_WDATA[AW-1:0];
				if (w_bcnt) bcnt_ff[g] <= REG_WDATA[CW-1:0];
			end
		end
		always_ff @(posedge MCLK) begin
			if (!RESETN) begin
				creq_ff[g] <= '0;
				ctgt_ff[g] <= '0;
				ccnt_ff[g] <= '0;
			end else if (CE) begin
				if (start | rld) begin
					creq_ff[g] <= breq_ff[g];
					ctgt_ff[g] <= btgt_ff[g];
					ccnt_ff[g] <= bcnt_ff[g];
				end else if (upd) begin
					creq_ff[g] <= nxt_req;
					ctgt_ff[g] <= nxt_tgt;
					ccnt_ff[g] <= nxt_cnt;
				end
			end
		end
		always_ff @(posedge MCLK) begin
			if (!RESETN) begin
				armed_ff[g] <= 1'b0;
				full_ff[g] <= 1'b0;
				irq_ff[g] <= 1'b0;
				tc_ff[g] <= 1'b0;
			end else if (CE) begin
				if (w_mode) armed_ff[g] <= wmode.enable;
				else if (stop) armed_ff[g] <= 1'b0;
				if (w_btgt) full_ff[g] <= 1'b1;
				else if (start_chain | (rld & chain)) full_ff[g] <= 1'b0;
				if (start_chain | (rld & chain)) irq_ff[g] <= 1'b1;
				else if (w_btgt | w_mode) irq_ff[g] <= 1'b0;
				if (trm) tc_ff[g] <= 1'b1;
				else if (w_mode) tc_ff[g] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			S_IDLE: begin
				if (pick_vld) nxt_st = S_HOLD;
			end
			S_HOLD: begin
				if (BUS_HOLD_GRANT) nxt_st = S_SRC1;
			end
			S_SRC1: nxt_st = S_SRC2;
			S_SRC2: begin
				if (BUS_RDY) nxt_st = S_DST1;
			end
			S_DST1: nxt_st = S_DST2;
			S_DST2: begin
				if (BUS_RDY) nxt_st = S_REL;
			end
			S_REL: begin
				if (!BUS_HOLD_GRANT) nxt_st = S_IDLE;
			end
			default: nxt_st = S_IDLE;
		endcase
	end

	always_comb begin
		nxt_bus = '0;
		case (nxt_st)
			S_SRC1, S_SRC2: begin
				nxt_bus.addr = 32'(src_addr);
				nxt_bus.rd = 1'b1;
			end
			S_DST1, S_DST2: begin
				nxt_bus.addr = 32'(dst_addr);
				nxt_bus.wdata = (st_ff == S_SRC2) ? BUS_RDATA : data_ff;
				nxt_bus.wr = 1'b1;
			end
			default: nxt_bus = '0;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			st_ff <= S_IDLE;
			act_ff <= '0;
			BUS_CYC <= '0;
		end else if (CE) begin
			st_ff <= nxt_st;
			BUS_CYC <= nxt_bus;
			if (st_ff == S_IDLE && pick_vld) act_ff <= pick_idx;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			data_ff <= DATA_RST;
			eop_seen_ff <= 1'b0;
		end else if (CE) begin
			if (st_ff == S_SRC2 && BUS_RDY) data_ff <= BUS_RDATA;
			if (st_ff == S_IDLE) eop_seen_ff <= 1'b0;
			else if (eop_hit) eop_seen_ff <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			ack_ff <= ACK_IDLE;
			eop_oe_ff <= 1'b0;
		end else if (CE) begin
			ack_ff <= req_nxt ? ACK_W'(act_ff) : ACK_IDLE;
			eop_oe_ff <= req_nxt & tc_last & ((nxt_st == S_SRC2) | (nxt_st == S_DST2));
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RESETN) rdata_ff <= '0;
		else if (CE) rdata_ff <= REG_RD ? rd_mux : '0;
	end

	assign REG_RDATA = rdata_ff;
	assign BUS_HOLD_REQ = (st_ff != S_IDLE) & (st_ff != S_REL);
	assign ENCODED_CHANNEL_ACK = ack_ff;
	assign END_OF_PROCESS_N_O = ~eop_oe_ff;
	assign END_OF_PROCESS_N_OE = eop_oe_ff;
	assign CHAIN_RELOAD_INTERRUPT = |irq_v;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wire logic w_any_mode = REG_WR & (reg_wd == WD_MODE) & (reg_ch == act_ff);
	wire logic w_any_btgt = REG_WR & (reg_wd == WD_BTGT) & (reg_ch == act_ff);
	property p_grant_bus;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && st_ff == S_HOLD && BUS_HOLD_GRANT) |=> (BUS_CYC.rd && st_ff == S_SRC1);
	endproperty
	a_grant_bus: assert property (p_grant_bus) else $error("bus cycle not one clock after grant");
	property p_ack_idle;
		@(posedge MCLK) disable iff (!RESETN)
		(!req_now) |-> (ENCODED_CHANNEL_ACK == ACK_IDLE);
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack not idle off requester access");
	property p_ack_req;
		@(posedge MCLK) disable iff (!RESETN)
		req_now |-> (ENCODED_CHANNEL_ACK == ACK_W'(act_ff));
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack does not name active channel");
	property p_eop_out;
		@(posedge MCLK) disable iff (!RESETN)
		END_OF_PROCESS_N_OE |-> (req_now && tc_last && (st_ff == S_SRC2 || st_ff == S_DST2));
	endproperty
	a_eop_out: assert property (p_eop_out) else $error("end driven outside last requester T2");
	property p_release;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end) |=> (!BUS_HOLD_REQ && st_ff == S_REL);
	endproperty
	a_release: assert property (p_release) else $error("bus kept after a transfer");
	property p_count_dec;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end && !term && !w_any_mode) |=> (ccnt_act == $past(nxt_cnt));
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented by one");
	property p_single_idle;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end && term && mode_act.proc == PROC_SINGLE && !w_any_mode)
			|=> !armed_ff[act_ff];
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("single buffer left armed");
	property p_auto_reload;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end && term && mode_act.proc == PROC_AUTO && !w_any_mode)
			|=> (creq_act == $past(breq_ff[act_ff]) && armed_ff[act_ff]);
	endproperty
	a_auto_reload: assert property (p_auto_reload) else $error("auto reload missing");
	property p_chain_irq;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end && term && mode_act.proc == PROC_CHAIN && full_ff[act_ff]
			&& !w_any_mode && !w_any_btgt) |=> (irq_ff[act_ff] && !full_ff[act_ff]);
	endproperty
	a_chain_irq: assert property (p_chain_irq) else $error("chain reload without irq");
	property p_chain_stop;
		@(posedge MCLK) disable iff (!RESETN)
		(CE && xfer_end && term && mode_act.proc == PROC_CHAIN && !full_ff[act_ff]
			&& !w_any_mode && !w_any_btgt) |=> !armed_ff[act_ff];
	endproperty
	a_chain_stop: assert property (p_chain_stop) else $error("empty chain not stopped");
endmodule
`default_nettype wire

// [logic/dmacms_pkg.sv]
`default_nettype none
package dmacms_pkg;
	// ----------------------------------------
	// register map: one block of eight words per channel
	// ----------------------------------------
	localparam int WORD_SH = 2;
	localparam int CH_SH = 5;
	localparam logic [2:0] WD_MODE = 3'h0;
	localparam logic [2:0] WD_BREQ = 3'h1;
	localparam logic [2:0] WD_BTGT = 3'h2;
	localparam logic [2:0] WD_BCNT = 3'h3;
	localparam logic [2:0] WD_CREQ = 3'h4;
	localparam logic [2:0] WD_CTGT = 3'h5;
	localparam logic [2:0] WD_CCNT = 3'h6;
	localparam logic [2:0] WD_STAT = 3'h7;
	// ----------------------------------------
	// mode fields and encodings
	// ----------------------------------------
	localparam int MODE_W = 8;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	localparam logic [1:0] STEP_INC = 2'h0;
	localparam logic [1:0] STEP_DEC = 2'h1;
	localparam logic [1:0] STEP_HOLD = 2'h2;
	localparam logic [1:0] PROC_SINGLE = 2'h0;
	localparam logic [1:0] PROC_AUTO = 2'h1;
	localparam logic [1:0] PROC_CHAIN = 2'h2;
	// ----------------------------------------
	// status bits and acknowledge code
	// ----------------------------------------
	localparam int ST_ARMED = 0;
	localparam int ST_FULL = 1;
	localparam int ST_IRQ = 2;
	localparam int ST_TC = 3;
	localparam int ST_BUSY = 4;
	localparam int ACK_W = 3;
	localparam logic [2:0] ACK_IDLE = 3'h4;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] proc;
		logic [1:0] tgt_step;
		logic [1:0] req_step;
		logic dir;
		logic enable;
	} dmacms_mode_s;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic rd;
		logic wr;
	} dmacms_bus_s;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_HOLD = 8'h02,
		S_SRC1 = 8'h04,
		S_SRC2 = 8'h08,
		S_DST1 = 8'h10,
		S_DST2 = 8'h20,
		S_REL = 8'h40
	} dmacms_state_e;
endpackage
`default_nettype wire

// [logic/dmacms_step.sv]
`timescale 1ns/10ps
`default_nettype none
module dmacms_step
	import dmacms_pkg::*;
#(
	parameter int AW = 32
) (
	input wire logic [AW-1:0] addr,
	input wire logic [1:0] step,
	output logic [AW-1:0] nxt
);
	// ----------------------------------------
	// address stepping after an access
	// ----------------------------------------
	wire logic [AW-1:0] up = addr + AW'(1);
	wire logic [AW-1:0] dn = addr - AW'(1);
	assign nxt = (step == STEP_INC) ? up : (step == STEP_DEC) ? dn : addr;
endmodule
`default_nettype wire

// [logic/dmacms_pick.sv]
`timescale 1ns/10ps
`default_nettype none
module dmacms_pick
	import dmacms_pkg::*;
#(
	parameter int N = 8,
	parameter int IW = $clog2(N)
) (
	input wire logic [N-1:0] req,
	output logic vld,
	output logic [IW-1:0] idx
);
	// ----------------------------------------
	// fixed priority, lowest channel first
	// ----------------------------------------
	assign vld = |req;
	always_comb begin
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IW'(i);
			end
		end
	end
endmodule
`default_nettype wire

// [dv/dmacms_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dmacms_host_model
	import dmacms_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic hold_req,
	output logic grant,
	input wire dmacms_bus_s cyc,
	output logic [31:0] rdata,
	output logic rdy,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [31:0] rd_addr
);
	// ----------------------------------------
	// host handover and memory with wait states
	// ----------------------------------------
	logic [1:0] kind;
	logic [1:0] kind_ff;
	logic [2:0] cnt_ff;
	logic [2:0] dly_ff;
	logic [31:0] last_ff;
	logic drv;
	assign kind = {cyc.rd, cyc.wr};
	assign rdy = (kind != 2'h0) && (kind == kind_ff) && (cnt_ff >= (slow ? 3'h3 : 3'h1));
	assign drv = cyc.rd && rdy;
	// released data lines show a changing pattern
	assign rdata = drv ? {24'h0, cyc.addr[7:0] ^ 8'h5A} : ~last_ff;
	always_ff @(posedge clk) begin
		last_ff <= rst_n ? rdata : 32'h0;
		kind_ff <= rst_n ? kind : 2'h0;
		cnt_ff <= (kind == kind_ff && cnt_ff != 3'h7) ? cnt_ff + 3'h1 : 3'h1;
		if (!rst_n || !hold_req) begin
			grant <= 1'b0;
			dly_ff <= 3'h0;
		end else if (dly_ff >= (slow ? 3'h3 : 3'h1)) begin
			grant <= 1'b1;
		end else begin
			dly_ff <= dly_ff + 3'h1;
		end
		if (cyc.wr && rdy) begin
			wr_addr <= cyc.addr;
			wr_data <= cyc.wdata;
		end
		if (drv) begin
			rd_addr <= cyc.addr;
		end
	end
endmodule
`default_nettype wire

// [dv/test_dma_channel_mode_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module test_dma_channel_mode_sequencer;
	import dmacms_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] req = 8'h00;
	logic hold, grant, eop_i, eop_o, eop_oe, bus_rdy, irq, hold_p, oe_p, g_p, g_pp;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic tb_eop_n = 1'b1;
	logic [2:0] ack, rd_ack, wr_ack;
	logic [31:0] bus_rdata, wr_addr, wr_data, rd_addr, d;
	dmacms_bus_s cyc;
	int num_errors = 0;
	int checks = 0;
	int holds = 0;
	int eops = 0;
	int e0;
	always #4 clk = ~clk;
	// pulled-up end-of-process pin
	assign eop_i = (eop_oe ? eop_o : 1'b1) & tb_eop_n;
	dmacms_top i_dut (.MCLK(clk), .RESETN(rst_n), .CE(ce), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.CHANNEL_SERVICE_REQUEST(req), .BUS_HOLD_REQ(hold), .BUS_HOLD_GRANT(grant),
		.ENCODED_CHANNEL_ACK(ack), .END_OF_PROCESS_N_I(eop_i), .END_OF_PROCESS_N_O(eop_o),
		.END_OF_PROCESS_N_OE(eop_oe), .BUS_CYC(cyc), .BUS_RDATA(bus_rdata),
		.BUS_RDY(bus_rdy), .CHAIN_RELOAD_INTERRUPT(irq));
	dmacms_host_model i_host (.clk(clk), .rst_n(rst_n), .slow(slow), .hold_req(hold),
		.grant(grant), .cyc(cyc), .rdata(bus_rdata), .rdy(bus_rdy), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_addr(rd_addr));
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input int ch, input logic [2:0] wd, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= {ch[2:0], wd, 2'b00};
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input int ch, input logic [2:0] wd, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= {ch[2:0], wd, 2'b00};
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic prog(input int ch, input dmacms_mode_s m, input logic [31:0] ra,
		input logic [31:0] ta, input logic [23:0] n);
		wr(ch, WD_BREQ, ra);
		wr(ch, WD_BCNT, {8'h0, n});
		wr(ch, WD_BTGT, ta);
		wr(ch, WD_MODE, {24'h0, m});
	endtask
	task automatic run(input int ch, input int n);
		int t;
		int i;
		t = holds + n;
		@(posedge clk);
		req[ch] <= 1'b1;
		for (i = 0; i < 4000 && holds < t; i++) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		req[ch] <= 1'b0;
		for (i = 0; i < 4000 && (hold || grant); i++) begin
			@(posedge clk);
			#1;
		end
		if (holds != t || hold || grant) begin
			num_errors++;
			print_verdict();
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic quiet(input int ch);
		int h;
		h = holds;
		@(posedge clk);
		req[ch] <= 1'b1;
		repeat (40) @(posedge clk);
		req[ch] <= 1'b0;
		chk(holds, h);
	endtask
	// ----------------------------------------
	// pin monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst_n) begin
			if (hold && !hold_p) holds++;
			if (eop_oe && !oe_p) eops++;
			if (cyc.rd && bus_rdy) rd_ack = ack;
			if (cyc.wr && bus_rdy) wr_ack = ack;
			if (!cyc.rd && !cyc.wr) chk(ack, ACK_IDLE);
			if (g_p && !g_pp) chk(cyc.rd, 1'b1);
			if (eop_oe) chk(eop_o, 1'b0);
		end
		hold_p = hold;
		oe_p = eop_oe;
		g_pp = g_p;
		g_p = grant;
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(3, WD_MODE, d);
		chk(d, 32'h0);
		chk({hold, irq, eop_oe, ack}, {3'h0, ACK_IDLE});
		prog(2, '{PROC_SINGLE, STEP_DEC, STEP_INC, DIR_WRITE, 1'b1}, 32'h1000, 32'h2000, 24'h2);
		e0 = eops;
		run(2, 3);
		chk(rd_addr, 32'h1002);
		chk(wr_addr, 32'h1FFE);
		chk(wr_data[7:0], 8'h02 ^ 8'h5A);
		chk({rd_ack, wr_ack}, {3'h2, ACK_IDLE});
		chk(eops - e0, 1);
		rd(2, WD_CREQ, d);
		chk(d, 32'h1003);
		rd(2, WD_CTGT, d);
		chk(d, 32'h1FFD);
		rd(2, WD_STAT, d);
		chk(d & 32'h19, 32'h08);
		quiet(2);
		ce <= 1'b0;
		wr(2, WD_BREQ, 32'h55);
		ce <= 1'b1;
		slow <= 1'b1;
		rd(2, WD_BREQ, d);
		chk(d, 32'h1000);
		prog(5, '{PROC_SINGLE, STEP_INC, STEP_HOLD, DIR_READ, 1'b1}, 32'h300, 32'h4000, 24'h0);
		tb_eop_n <= 1'b0;
		run(5, 1);
		tb_eop_n <= 1'b1;
		slow <= 1'b0;
		chk(rd_addr, 32'h4000);
		chk(wr_addr, 32'h300);
		chk(wr_data[7:0], 8'h5A);
		chk({rd_ack, wr_ack}, {ACK_IDLE, 3'h5});
		rd(5, WD_CREQ, d);
		chk(d, 32'h300);
		rd(5, WD_CTGT, d);
		chk(d, 32'h4001);
		rd(5, WD_STAT, d);
		chk(d & 32'h19, 32'h08);
		rd(2, WD_CREQ, d);
		chk(d, 32'h1003);
		prog(1, '{PROC_AUTO, STEP_INC, STEP_INC, DIR_WRITE, 1'b1}, 32'h500, 32'h600, 24'h1);
		run(1, 2);
		rd(1, WD_CREQ, d);
		chk(d, 32'h500);
		rd(1, WD_STAT, d);
		chk(d & 32'h1, 32'h1);
		run(1, 2);
		chk(wr_addr, 32'h601);
		tb_eop_n <= 1'b0;
		run(1, 1);
		tb_eop_n <= 1'b1;
		chk(wr_addr, 32'h600);
		rd(1, WD_CCNT, d);
		chk(d, 32'h1);
		wr(1, WD_MODE, 32'h0);
		prog(0, '{PROC_CHAIN, STEP_INC, STEP_INC, DIR_WRITE, 1'b1}, 32'h700, 32'h800, 24'h1);
		rd(0, WD_STAT, d);
		chk(d & 32'h7, 32'h5);
		chk(irq, 1'b1);
		wr(0, WD_BREQ, 32'h900);
		wr(0, WD_BTGT, 32'hA00);
		rd(0, WD_STAT, d);
		chk(d & 32'h7, 32'h3);
		chk(irq, 1'b0);
		tb_eop_n <= 1'b0;
		run(0, 1);
		tb_eop_n <= 1'b1;
		chk(wr_addr, 32'h800);
		rd(0, WD_CREQ, d);
		chk(d, 32'h900);
		rd(0, WD_STAT, d);
		chk(d & 32'h7, 32'h5);
		run(0, 2);
		chk(wr_addr, 32'hA01);
		rd(0, WD_STAT, d);
		chk(d & 32'h9, 32'h8);
		quiet(0);
		print_verdict();
	end
endmodule
`default_nettype wire
